// >>> inc/sbat_pkg.sv
// Shared constants and types for the system bus arbitration block.
// Assumes one 250 MHz clock and active-low bus pins with pull-ups.
package sbat_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int BADDR_W = 5;
  localparam int BEAT_W = 4;
  localparam logic [3:0] BURST_BEATS = 4'h8;
  localparam logic [3:0] SINGLE_BEATS = 4'h1;
  localparam logic [4:0] BURST_STEP = 5'h01;
  localparam logic [4:0] BADDR_RST = 5'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PS = 4000;
  // Address busy is driven inactive this long before release; data busy always for one cycle
  localparam int RELEASE_PS = 4000;
  localparam int RELEASE_CYC_RAW = RELEASE_PS / CLOCK_PS;
  localparam int RELEASE_CYC = (RELEASE_CYC_RAW < 1) ? 1 : RELEASE_CYC_RAW;

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  localparam logic PIN_ON = 1'b0;
  localparam logic PIN_OFF = 1'b1;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [1:0] {
    A_IDLE,
    A_REQ,
    A_TENURE,
    A_RELEASE
  } sbat_astate_e;

  typedef enum logic [1:0] {
    D_IDLE,
    D_WAIT,
    D_TENURE,
    D_RELEASE
  } sbat_dstate_e;

endpackage : sbat_pkg

// >>> inc/sbat_burst_if.sv
// Link between the tenure logic and the burst address generator.
// Both ends share the block clock.
`timescale 1ns/1ps
interface sbat_burst_if;
  logic load;
  logic beat;
  logic [sbat_pkg::BADDR_W-1:0] start;
  logic [sbat_pkg::BADDR_W-1:0] addr;

  modport ctl (
    output load,
    output beat,
    output start,
    input addr
  );

  modport gen (
    input load,
    input beat,
    input start,
    output addr
  );
endinterface : sbat_burst_if

// >>> hdl/sbat_burst_addr.sv
// Low-order burst address generator for memories without incrementers.
// Expects load on tenure start and one beat pulse per data beat.
`timescale 1ns/1ps
module sbat_burst_addr (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Control
  sbat_burst_if.gen bus
);

  typedef struct packed {
    logic [sbat_pkg::BADDR_W-1:0] addr;
  } sbat_gen_s;

  sbat_gen_s st;
  sbat_gen_s next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (bus.load) begin
      next_st.addr = bus.start;
    end else if (bus.beat) begin
      // Wraps inside the low-order field, as burst memories expect
      next_st.addr = st.addr + sbat_pkg::BURST_STEP;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st.addr <= sbat_pkg::BADDR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.addr = st.addr;

endmodule : sbat_burst_addr

// >>> hdl/sbat_arbiter.sv
// Arbitration and tenure signalling on the shared system bus.
// Assumes pins are synchronous, active low and pulled up externally.
// How it works
// (RULE1) External arbiter mode: we drive bus request out to ask for bus.
// (RULE2) Internal arbiter mode: bus request is an input from outside masters.
// (RULE3) Internal arbiter mode: we drive bus grant to outside master.
// (RULE4) External arbiter mode: bus grant is an input giving us the bus.
// (RULE5) Data grant is our output as arbiter, else our input.
// (RULE6) Address busy held asserted for our whole address tenure.
// (RULE7) After acknowledge, address busy driven high briefly, then released.
// (RULE8) Never take address bus while someone else shows address busy.
// (RULE9) Data busy held asserted for our whole data tenure.
// (RULE10) After last transfer ack, data busy driven high briefly, released.
// (RULE11) Never take data bus while someone else shows data busy.
// (RULE12) Every new address tenure starts with a transfer start.
// (RULE13) We pulse transfer start when our internal master begins.
// (RULE14) Outside transfer start: report it and answer as slave if hit.
// (RULE15) A slave acknowledges the address once it recognises it.
// (RULE16) Address acknowledge ends the address tenure for both sides.
// (RULE17) On retry the current master abandons and tries later.
// (RULE18) Outside masters may retry for coherency or deadlock avoidance.
// (RULE19) Memory controller drives five burst address outputs.
// (RULE20) Arbiter mode is captured at reset and then fixed.
// (RULE21) Busy, request, grant are active low with shared pull-up.
`timescale 1ns/1ps
module sbat_arbiter #(
  parameter int BEAT_W = sbat_pkg::BEAT_W
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Static configuration
  input wire logic i_internal_arbiter,
  // Internal master side
  input wire logic i_master_req,
  input wire logic i_master_burst,
  input wire logic [sbat_pkg::BADDR_W-1:0] i_master_addr,
  output logic o_master_granted,
  output logic o_master_retry,
  output logic o_master_done,
  // Slave side for outside tenures
  input wire logic i_slave_hit,
  input wire logic i_slave_addr,
  output logic o_ext_start,
  output logic o_ext_data,
  // Bus request pin
  input wire logic i_bus_request_n,
  output logic o_bus_request_n,
  output logic o_bus_request_oe,
  // Bus grant pin
  input wire logic i_bus_grant_n,
  output logic o_bus_grant_n,
  output logic o_bus_grant_oe,
  // Data bus grant pin
  input wire logic i_data_bus_grant_n,
  output logic o_data_bus_grant_n,
  output logic o_data_bus_grant_oe,
  // Address bus busy pin
  input wire logic i_address_bus_busy_n,
  output logic o_address_bus_busy_n,
  output logic o_address_bus_busy_oe,
  // Data bus busy pin
  input wire logic i_data_bus_busy_n,
  output logic o_data_bus_busy_n,
  output logic o_data_bus_busy_oe,
  // Transfer start pin
  input wire logic i_transfer_start_n,
  output logic o_transfer_start_n,
  output logic o_transfer_start_oe,
  // Address acknowledge pin
  input wire logic i_address_acknowledge_n,
  output logic o_address_acknowledge_n,
  output logic o_address_acknowledge_oe,
  // Address retry pin, monitored only
  input wire logic i_address_retry_n,
  // Transfer acknowledge pin, monitored only
  input wire logic i_transfer_acknowledge_n,
  // Burst address outputs
  output logic [sbat_pkg::BADDR_W-1:0] o_burst_address_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic int_mode;
    sbat_pkg::sbat_astate_e astate;
    sbat_pkg::sbat_dstate_e dstate;
    logic [BEAT_W-1:0] beats;
    logic [BEAT_W-1:0] rel_cnt;
    logic burst;
    logic ts_drv;
    logic address_acknowledge_drv;
    logic bg_out;
    logic dbg_out;
    logic ext_aphase;
    logic ext_dphase;
    logic ext_dbb_seen;
    logic retry;
    logic done;
    logic ext_start;
  } sbat_state_s;

  sbat_state_s st;
  sbat_state_s next_st;

  sbat_burst_if burst_bus ();

  // Active-low pin asserted
  function automatic logic on(input logic pin_n);
    on = (pin_n == sbat_pkg::PIN_ON);
  endfunction : on

  localparam logic [BEAT_W-1:0] REL_LAST =
    BEAT_W'(sbat_pkg::RELEASE_CYC - 1);

  logic abb_drv;
  logic dbb_drv;
  logic abb_other;
  logic dbb_other;
  logic ts_other;
  logic own_agrant;
  logic own_dgrant;
  logic address_acknowledge_seen;
  logic retry_seen;
  logic ta_seen;
  logic [BEAT_W-1:0] need_beats;

  // ----------------------------------------
  // Pin sensing
  // ----------------------------------------
  assign abb_drv = (st.astate == sbat_pkg::A_TENURE) ||
                   (st.astate == sbat_pkg::A_RELEASE);
  assign dbb_drv = (st.dstate == sbat_pkg::D_TENURE) ||
                   (st.dstate == sbat_pkg::D_RELEASE);
  // Our own drive is never mistaken for another master
  assign abb_other = on(i_address_bus_busy_n) && !abb_drv;
  assign dbb_other = on(i_data_bus_busy_n) && !dbb_drv;
  assign ts_other = on(i_transfer_start_n) && !st.ts_drv;
  assign address_acknowledge_seen = on(i_address_acknowledge_n);
  assign retry_seen = on(i_address_retry_n);
  assign ta_seen = on(i_transfer_acknowledge_n);
  assign need_beats = st.burst ? BEAT_W'(sbat_pkg::BURST_BEATS) :
                                 BEAT_W'(sbat_pkg::SINGLE_BEATS);

  // (RULE4) Grant pin in external mode
  // (RULE8) Held off while other owner busy
  assign own_agrant = (st.int_mode ? !st.bg_out : on(i_bus_grant_n)) &&
                      !abb_other;
  // (RULE5) Data grant pin or own decision
  // (RULE11) Held off while data busy
  assign own_dgrant = (st.int_mode ? !st.dbg_out && !st.ext_dphase :
                       on(i_data_bus_grant_n)) && !dbb_other;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.ts_drv = 1'b0;
    next_st.address_acknowledge_drv = 1'b0;
    next_st.retry = 1'b0;
    next_st.done = 1'b0;
    next_st.ext_start = 1'b0;

    // Address tenure of our internal master
    case (st.astate)
      sbat_pkg::A_IDLE: begin
        // One tenure in flight: the data phase must drain first
        if (i_master_req && st.dstate == sbat_pkg::D_IDLE) begin
          next_st.astate = sbat_pkg::A_REQ;
          next_st.burst = i_master_burst;
        end
      end
      sbat_pkg::A_REQ: begin
        if (own_agrant) begin
          // (RULE13) Start pulse begins tenure
          next_st.astate = sbat_pkg::A_TENURE;
          next_st.ts_drv = 1'b1;
        end
      end
      sbat_pkg::A_TENURE: begin
        if (retry_seen) begin
          // (RULE17) Abandon on retry
          next_st.astate = sbat_pkg::A_RELEASE;
          next_st.rel_cnt = '0;
          next_st.retry = 1'b1;
        end else if (address_acknowledge_seen && !st.ts_drv) begin
          // (RULE16) Acknowledge ends tenure
          next_st.astate = sbat_pkg::A_RELEASE;
          next_st.rel_cnt = '0;
          next_st.dstate = sbat_pkg::D_WAIT;
          next_st.beats = '0;
        end
      end
      sbat_pkg::A_RELEASE: begin
        // (RULE7) Drive high, then release
        if (st.rel_cnt == REL_LAST) begin
          next_st.astate = sbat_pkg::A_IDLE;
        end else begin
          next_st.rel_cnt = st.rel_cnt + 1'b1;
        end
      end
      default: begin
        next_st.astate = sbat_pkg::A_IDLE;
      end
    endcase

    // Data tenure of our internal master
    case (st.dstate)
      sbat_pkg::D_IDLE: begin
      end
      sbat_pkg::D_WAIT: begin
        if (retry_seen) begin
          // (RULE17) Late retry still cancels
          next_st.dstate = sbat_pkg::D_IDLE;
          next_st.retry = 1'b1;
        end else if (own_dgrant) begin
          next_st.dstate = sbat_pkg::D_TENURE;
        end
      end
      sbat_pkg::D_TENURE: begin
        // (RULE9) Busy until last beat
        if (ta_seen) begin
          next_st.beats = st.beats + 1'b1;
          if (st.beats + 1'b1 == need_beats) begin
            next_st.dstate = sbat_pkg::D_RELEASE;
            next_st.done = 1'b1;
          end
        end
      end
      sbat_pkg::D_RELEASE: begin
        // (RULE10) Inactive one cycle, release
        next_st.dstate = sbat_pkg::D_IDLE;
      end
      default: begin
        next_st.dstate = sbat_pkg::D_IDLE;
      end
    endcase

    // (RULE14) Outside tenure start seen
    // (RULE12) Start marks new tenure
    if (ts_other) begin
      next_st.ext_start = 1'b1;
      next_st.ext_aphase = 1'b1;
    end else if (st.ext_aphase) begin
      if (retry_seen) begin
        next_st.ext_aphase = 1'b0;
      end else if (address_acknowledge_seen) begin
        // (RULE16) Acknowledge ends outside tenure
        next_st.ext_aphase = 1'b0;
        next_st.ext_dphase = 1'b1;
        next_st.ext_dbb_seen = 1'b0;
      end else if (i_slave_hit && !st.address_acknowledge_drv) begin
        // (RULE15) Acknowledge on recognition
        next_st.address_acknowledge_drv = 1'b1;
      end
    end

    // Outside data phase lasts until its busy rises again
    if (st.ext_dphase) begin
      if (dbb_other) begin
        next_st.ext_dbb_seen = 1'b1;
      end else if (st.ext_dbb_seen) begin
        next_st.ext_dphase = 1'b0;
      end
    end

    // (RULE3) Grant outside master when idle
    // Our master wins a tie; outside waits
    next_st.bg_out = st.int_mode && on(i_bus_request_n) &&
                     st.astate == sbat_pkg::A_IDLE && !i_master_req &&
                     st.dstate == sbat_pkg::D_IDLE;
    // (RULE5) Data grant when bus free
    next_st.dbg_out = st.int_mode && st.ext_dphase && !st.ext_dbb_seen &&
                      st.dstate == sbat_pkg::D_IDLE && !dbb_other;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      // (RULE20) Mode sampled during reset
      st.int_mode <= i_internal_arbiter;
      st.astate <= sbat_pkg::A_IDLE;
      st.dstate <= sbat_pkg::D_IDLE;
      st.beats <= '0;
      st.rel_cnt <= '0;
      st.burst <= 1'b0;
      st.ts_drv <= 1'b0;
      st.address_acknowledge_drv <= 1'b0;
      st.bg_out <= 1'b0;
      st.dbg_out <= 1'b0;
      st.ext_aphase <= 1'b0;
      st.ext_dphase <= 1'b0;
      st.ext_dbb_seen <= 1'b0;
      st.retry <= 1'b0;
      st.done <= 1'b0;
      st.ext_start <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Burst address generator
  // ----------------------------------------
  // (RULE19) Load at start, step per beat
  assign burst_bus.load = next_st.ts_drv || (ts_other && i_slave_addr);
  assign burst_bus.start = next_st.ts_drv ? i_master_addr :
                           {sbat_pkg::BADDR_W{1'b0}};
  assign burst_bus.beat = ta_seen &&
                          (st.dstate == sbat_pkg::D_TENURE || st.ext_dphase);

  sbat_burst_addr u_burst (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .bus(burst_bus.gen)
  );

  assign o_burst_address_out = burst_bus.addr;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // (RULE21) Undriven lines float to the pull-up
  // (RULE1) Request out in external mode
  // (RULE2) Released as input in internal mode
  assign o_bus_request_oe = !st.int_mode;
  assign o_bus_request_n = (st.astate == sbat_pkg::A_REQ) ?
                           sbat_pkg::PIN_ON : sbat_pkg::PIN_OFF;
  assign o_bus_grant_oe = st.int_mode;
  assign o_bus_grant_n = st.bg_out ? sbat_pkg::PIN_ON : sbat_pkg::PIN_OFF;
  assign o_data_bus_grant_oe = st.int_mode;
  assign o_data_bus_grant_n = st.dbg_out ? sbat_pkg::PIN_ON :
                                           sbat_pkg::PIN_OFF;
  // (RULE6) Busy low through tenure
  assign o_address_bus_busy_oe = abb_drv;
  assign o_address_bus_busy_n = (st.astate == sbat_pkg::A_TENURE) ?
                                sbat_pkg::PIN_ON : sbat_pkg::PIN_OFF;
  assign o_data_bus_busy_oe = dbb_drv;
  assign o_data_bus_busy_n = (st.dstate == sbat_pkg::D_TENURE) ?
                             sbat_pkg::PIN_ON : sbat_pkg::PIN_OFF;
  assign o_transfer_start_oe = st.ts_drv;
  assign o_transfer_start_n = sbat_pkg::PIN_ON;
  assign o_address_acknowledge_oe = st.address_acknowledge_drv;
  assign o_address_acknowledge_n = sbat_pkg::PIN_ON;

  // ----------------------------------------
  // User side
  // ----------------------------------------
  assign o_master_granted = st.ts_drv;
  assign o_master_retry = st.retry;
  assign o_master_done = st.done;
  assign o_ext_start = st.ext_start;
  assign o_ext_data = st.ext_dphase;

endmodule : sbat_arbiter

// >>> testbench/sbat_checker.sv
// Assertions on the pins and master pulses of sbat_arbiter.
// Bound to sbat_arbiter; pins are active low, oe high = driven.
`timescale 1ns/1ps
module sbat_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Resolved pins
  input wire logic i_bus_request_n,
  input wire logic i_bus_grant_n,
  input wire logic i_address_bus_busy_n,
  input wire logic i_data_bus_busy_n,
  input wire logic i_transfer_start_n,
  input wire logic i_address_acknowledge_n,
  input wire logic i_address_retry_n,
  // Pin drive
  input wire logic o_bus_request_oe,
  input wire logic o_bus_grant_n,
  input wire logic o_bus_grant_oe,
  input wire logic o_data_bus_grant_oe,
  input wire logic o_address_bus_busy_n,
  input wire logic o_address_bus_busy_oe,
  input wire logic o_data_bus_busy_n,
  input wire logic o_data_bus_busy_oe,
  input wire logic o_transfer_start_n,
  input wire logic o_transfer_start_oe,
  input wire logic o_address_acknowledge_n,
  input wire logic o_address_acknowledge_oe,
  // Master side
  input wire logic o_master_granted,
  input wire logic o_master_retry,
  input wire logic o_ext_start
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  // ----------------------------------------
  // Tenure steps
  // ----------------------------------------
  sequence s_abb_drop;
    o_address_bus_busy_oe && o_address_bus_busy_n ##1 !o_address_bus_busy_oe;
  endsequence
  sequence s_start;
    !o_transfer_start_n && o_master_granted && o_address_bus_busy_oe &&
      !o_address_bus_busy_n ##1 !o_transfer_start_oe;
  endsequence
  a_mode_fixed: assert property (
    $stable(o_bus_request_oe) && $stable(o_bus_grant_oe))
    else $error("arbiter mode changed");
  a_dir_by_mode: assert property (
    o_bus_grant_oe != o_bus_request_oe &&
      o_data_bus_grant_oe == o_bus_grant_oe)
    else $error("pin direction wrong for mode");
  a_start_pulse: assert property (
    o_transfer_start_oe |-> s_start)
    else $error("start not a single cycle with busy");
  a_abb_release: assert property (
    o_address_bus_busy_oe && !o_address_bus_busy_n && !o_transfer_start_oe
      && !i_address_acknowledge_n |=> s_abb_drop)
    else $error("address busy release wrong");
  a_abb_respect: assert property (
    !i_address_bus_busy_n && !o_address_bus_busy_oe |=> !o_transfer_start_oe)
    else $error("start while address bus busy");
  a_dbb_release: assert property (
    $fell(o_data_bus_busy_oe) |-> $past(o_data_bus_busy_n))
    else $error("data busy released while low");
  a_dbb_respect: assert property (
    $rose(o_data_bus_busy_oe) |-> $past(i_data_bus_busy_n))
    else $error("data bus taken while busy");
  a_ext_grant: assert property (
    o_master_granted && o_bus_request_oe |-> !$past(i_bus_grant_n))
    else $error("tenure without grant");
  a_int_grant: assert property (
    $fell(o_bus_grant_n) && o_bus_grant_oe |-> !$past(i_bus_request_n))
    else $error("grant without request");
  a_ack_pulse: assert property (
    o_address_acknowledge_oe |->
      !o_address_acknowledge_n ##1 !o_address_acknowledge_oe)
    else $error("acknowledge not one cycle");
  a_ext_seen: assert property (
    !i_transfer_start_n && !o_transfer_start_oe |=> o_ext_start)
    else $error("outside start not reported");
  a_retry_quit: assert property (
    o_address_bus_busy_oe && !o_address_bus_busy_n && !o_transfer_start_oe
      && !i_address_retry_n |-> ##[1:2] o_master_retry)
    else $error("retry not obeyed");
endmodule : sbat_checker

// >>> testbench/sbat_far_model.sv
// Far side: external arbiter, slave and outside master.
// Bit order of pins: req gnt dgnt abusy dbusy start aok; 1 = released.
`timescale 1ns/1ps
module sbat_far_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Scenario controls
  input wire logic i_int,
  input wire logic i_slow,
  input wire logic i_retry,
  input wire logic i_hold,
  // Pins
  input wire logic [6:0] i_pin,
  output logic [6:0] o_pin,
  output logic o_rty_n,
  output logic o_tok_n
);
  logic [6:0] own = 7'h7F;
  logic [6:0] arb = 7'h7F;
  logic [2:0] w = 3'h0;
  logic [2:0] v = 3'h0;
  logic pend = 1'b0;
  logic dpend = 1'b0;
  logic tog = 1'b0;
  logic mtok = 1'b1;
  wire [2:0] dly = i_slow ? 3'h3 : 3'h0;
  assign o_pin = own & arb;
  // beats while the device holds data busy (every other cycle when i_slow), or while mtok is low
  // Slave beats in either arbiter mode
  assign o_tok_n = mtok && !(!i_pin[4] && own[4] && (tog || !i_slow));
  // ----------------------------------------
  // Arbiter and slave
  // ----------------------------------------
  always @(posedge i_clock) begin
    tog <= ~tog;
    if (i_srst) begin
      arb <= 7'h7F;
      o_rty_n <= 1'b1;
      pend <= 1'b0;
      dpend <= 1'b0;
      w <= 3'h0;
    end else begin
      if (i_pin[0]) w <= 3'h0;
      else if (w != 3'h7) w <= w + 3'h1;
      arb[1] <= i_int || i_pin[0] || w < dly;
      if (!i_pin[4]) dpend <= 1'b0;
      arb[2] <= i_int || !dpend;
      arb[3] <= ~i_hold;
      o_rty_n <= 1'b1;
      arb[6] <= 1'b1;
      if (!i_pin[5] && own[5]) begin
        pend <= 1'b1;
        v <= 3'h0;
      end else if (pend) begin
        v <= v + 3'h1;
        if (v == dly) begin
          pend <= 1'b0;
          if (i_retry) o_rty_n <= 1'b0;
          else begin
            arb[6] <= 1'b0;
            dpend <= 1'b1;
          end
        end
      end
    end
  end
  task automatic ext_tenure(output logic ok);
    int k;
    k = 0;
    @(posedge i_clock);
    own[0] <= ~i_int;
    do begin
      @(posedge i_clock);
      k++;
    end while (i_int && i_pin[1] && k < 50);
    own <= 7'h57;
    @(posedge i_clock);
    own <= 7'h77;
    do begin
      @(posedge i_clock);
      k++;
    end while (i_pin[6] && k < 100);
    own <= 7'h7F;
    do begin
      @(posedge i_clock);
      k++;
    end while (i_int && i_pin[2] && k < 150);
    own <= 7'h6F;
    mtok <= 1'b0;
    @(posedge i_clock);
    own <= 7'h7F;
    mtok <= 1'b1;
    @(posedge i_clock);
    ok = k < 150;
  endtask : ext_tenure
endmodule : sbat_far_model

// >>> testbench/tb_top.sv
// Self-checking bench for sbat_arbiter with the far-side model.
// Pins resolve as wired-AND with pull-ups; one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
  cmp_count++; \
  if ((s) !== (e)) begin \
    num_errors++; \
    $display("FAIL %s exp %0h got %0h", n, e, s); \
  end \
end
`define WAITF(c) begin \
  k = 0; \
  while (!(c) && k < 300) begin \
    @(negedge i_clock); \
    k++; \
  end \
  if (!(c)) begin \
    num_errors++; \
    results(); \
  end \
end
module tb_top;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic mode = 1'b0;
  logic req = 1'b0;
  logic burst = 1'b0;
  logic [4:0] addr = 5'h00;
  logic hit = 1'b0;
  logic slow = 1'b0;
  logic rtry = 1'b0;
  logic hold = 1'b0;
  logic gnt, rty, done, xs, xd, rty_n, tok_n, ok, was_rty;
  logic [6:0] po, pe, mo;
  logic [6:0] seen = 7'h00;
  logic [4:0] baddr;
  wire [6:0] pin = (po | ~pe) & mo;
  int num_errors = 0;
  int cmp_count = 0;
  int k, beats, grants, xss, xds;
  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    seen <= seen | (pe & ~po);
    if (pe[4] && !po[4] && !tok_n) beats <= beats + 1;
    if (gnt) grants <= grants + 1;
    if (xs) xss <= xss + 1;
    if (xd) xds <= xds + 1;
  end
  sbat_far_model u_far (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_int(mode),
    .i_slow(slow),
    .i_retry(rtry),
    .i_hold(hold),
    .i_pin(pin),
    .o_pin(mo),
    .o_rty_n(rty_n),
    .o_tok_n(tok_n)
  );
  sbat_arbiter DUT (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_internal_arbiter(mode),
    .i_master_req(req),
    .i_master_burst(burst),
    .i_master_addr(addr),
    .o_master_granted(gnt),
    .o_master_retry(rty),
    .o_master_done(done),
    .i_slave_hit(hit),
    .i_slave_addr(hit),
    .o_ext_start(xs),
    .o_ext_data(xd),
    .i_bus_request_n(pin[0]),
    .o_bus_request_n(po[0]),
    .o_bus_request_oe(pe[0]),
    .i_bus_grant_n(pin[1]),
    .o_bus_grant_n(po[1]),
    .o_bus_grant_oe(pe[1]),
    .i_data_bus_grant_n(pin[2]),
    .o_data_bus_grant_n(po[2]),
    .o_data_bus_grant_oe(pe[2]),
    .i_address_bus_busy_n(pin[3]),
    .o_address_bus_busy_n(po[3]),
    .o_address_bus_busy_oe(pe[3]),
    .i_data_bus_busy_n(pin[4]),
    .o_data_bus_busy_n(po[4]),
    .o_data_bus_busy_oe(pe[4]),
    .i_transfer_start_n(pin[5]),
    .o_transfer_start_n(po[5]),
    .o_transfer_start_oe(pe[5]),
    .i_address_acknowledge_n(pin[6]),
    .o_address_acknowledge_n(po[6]),
    .o_address_acknowledge_oe(pe[6]),
    .i_address_retry_n(rty_n),
    .i_transfer_acknowledge_n(tok_n),
    .o_burst_address_out(baddr)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task clr();
    seen = 7'h00;
    beats = 0;
    grants = 0;
    xss = 0;
    xds = 0;
  endtask : clr
  task do_reset(input logic m);
    @(negedge i_clock);
    i_srst = 1'b1;
    mode = m;
    repeat (16) @(negedge i_clock);
    i_srst = 1'b0;
    clr();
  endtask : do_reset
  task go(input logic b, input logic [4:0] a);
    clr();
    burst = b;
    addr = a;
    req = 1'b1;
  endtask : go
  // Request held until granted, then done or retry ends it
  task end_xfer();
    `WAITF(gnt === 1'b1)
    req = 1'b0;
    `WAITF(done === 1'b1 || rty === 1'b1)
    was_rty = rty;
    repeat (3) @(negedge i_clock);
  endtask : end_xfer
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_idle();
    `CHK("oe", 7'h01, pe)
    `CHK("pins", 7'h7F, pin)
    `CHK("baddr", 5'h00, baddr)
  endtask : t_idle
  task t_single();
    go(1'b0, 5'h0A);
    end_xfer();
    `CHK("req", 1'b1, seen[0])
    `CHK("start", 1'b1, seen[5])
    `CHK("beats", 1, beats)
    `CHK("rel", 7'h01, pe)
    `CHK("baddr", 5'h0B, baddr)
  endtask : t_single
  task t_burst();
    slow = 1'b1;
    go(1'b1, 5'h1C);
    end_xfer();
    slow = 1'b0;
    `CHK("beats", 8, beats)
    `CHK("rel", 7'h01, pe)
    `CHK("baddr", 5'h04, baddr)
  endtask : t_burst
  task t_hold();
    hold = 1'b1;
    go(1'b0, 5'h03);
    repeat (20) @(negedge i_clock);
    `CHK("held", 0, grants)
    hold = 1'b0;
    end_xfer();
    `CHK("after", 1, beats)
  endtask : t_hold
  task t_retry();
    rtry = 1'b1;
    go(1'b0, 5'h11);
    end_xfer();
    rtry = 1'b0;
    `CHK("retry", 1'b1, was_rty)
    `CHK("nodata", 0, beats)
    `CHK("rel", 7'h01, pe)
  endtask : t_retry
  task t_outside();
    hit = 1'b1;
    clr();
    u_far.ext_tenure(ok);
    @(negedge i_clock);
    hit = 1'b0;
    `CHK("xdone", 1'b1, ok)
    `CHK("xstart", 1, xss)
    `CHK("xdata", 3, xds)
    `CHK("ack", 1'b1, seen[6])
    `CHK("xbaddr", 5'h01, baddr)
  endtask : t_outside
  task t_internal();
    do_reset(1'b1);
    `CHK("oe", 7'h06, pe)
    hit = 1'b1;
    u_far.ext_tenure(ok);
    @(negedge i_clock);
    hit = 1'b0;
    `CHK("xdone", 1'b1, ok)
    `CHK("gnt", 1'b1, seen[1])
    `CHK("dgnt", 1'b1, seen[2])
    go(1'b0, 5'h15);
    end_xfer();
    `CHK("ibeats", 1, beats)
    `CHK("ibaddr", 5'h16, baddr)
  endtask : t_internal
  initial begin
    do_reset(1'b0);
    t_idle();
    t_single();
    t_burst();
    t_hold();
    t_retry();
    t_outside();
    t_internal();
    results();
  end
endmodule : tb_top
bind sbat_arbiter sbat_checker u_chk (.*);
